// ===== include/ecp_defs.vh
// constants for the external clock prescaler
`ifndef ECP_DEFS_VH
`define ECP_DEFS_VH

`define ECP_OFF_CTRL       12'h000
`define ECP_AW             12
`define ECP_EN_BIT         15
`define ECP_SUSP_BIT       8
`define ECP_DIV_MSB        7
`define ECP_DIV_RST        8'h07
`define ECP_DIV_ZERO       8'h00
`define ECP_HTRANS_NONSEQ  2'h2
`define ECP_HSIZE_HALF     3'h1
`define ECP_HSIZE_WORD     3'h2
`define ECP_PRIV_BIT       1
`define ECP_HALF_SEL_BIT   1

`endif

// ===== rtl/ecp_sync.v
// two flip-flop synchroniser for a single level
`timescale 1ns/1ps
module ecp_sync (
	hclk,
	hresetn,
	d_in,
	q_out
);
	input  wire hclk;
	input  wire hresetn;
	input  wire d_in;
	output wire q_out;

	reg meta_ff;
	reg sync_ff;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule // ecp_sync

// ===== rtl/ecp_divider.v
// programmable divider: output rises at terminal count, falls at the half point
`timescale 1ns/1ps
`include "ecp_defs.vh"
module ecp_divider (
	hclk,
	hresetn,
	run,
	pend_div,
	clk_level,
	period_end
);
	input  wire       hclk;
	input  wire       hresetn;
	input  wire       run;
	input  wire [7:0] pend_div;
	output wire       clk_level;
	output wire       period_end;

	reg  [7:0] cnt_ff;
	reg  [7:0] act_div_ff;
	reg        phase_ff;
	reg  [7:0] nxt_cnt;
	reg  [7:0] nxt_act_div;
	reg        nxt_phase;
	wire       hit;

	// one output clock period is act_div+1 input cycles; edges at half points
	wire [8:0] half_pt = ({1'b0, act_div_ff} + 9'h001) >> 1;
	assign hit        = (cnt_ff == act_div_ff);
	assign period_end = run & hit;

	always @* begin
		nxt_cnt     = cnt_ff;
		nxt_act_div = act_div_ff;
		nxt_phase   = phase_ff;
		if (run) begin
			if (hit) begin
				nxt_cnt     = `ECP_DIV_ZERO;
				nxt_act_div = pend_div;
				nxt_phase   = 1'b1;
			end else begin
				nxt_cnt   = cnt_ff + 8'h01;
				// divide by 1 stays high: ratio of one holds clk_level at 1, with no edges
				nxt_phase = ((cnt_ff + 8'h01) < half_pt[7:0]) | (act_div_ff == `ECP_DIV_ZERO);
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_ff     <= `ECP_DIV_ZERO;
			act_div_ff <= `ECP_DIV_RST;
			phase_ff   <= 1'b0;
		end else begin
			cnt_ff     <= nxt_cnt;
			act_div_ff <= nxt_act_div;
			phase_ff   <= nxt_phase;
		end
	end

	assign clk_level = phase_ff;
endmodule // ecp_divider

// ===== rtl/ecp_top.v
// external clock prescaler: control register, divider and pin mux
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "ecp_defs.vh"
module ecp_top (
	hclk,
	hresetn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hprot,
	hwdata,
	hready,
	hrdata,
	hreadyout,
	hresp,
	suspend_req,
	pin_direction_bit,
	pin_out_value,
	shared_port_pin_in,
	shared_port_pin_out,
	shared_port_pin_oe,
	pin_in_value
);
	input  wire        hclk;
	input  wire        hresetn;
	input  wire        hsel;
	input  wire [31:0] haddr;
	input  wire [1:0]  htrans;
	input  wire        hwrite;
	input  wire [2:0]  hsize;
	input  wire [3:0]  hprot;
	input  wire [31:0] hwdata;
	input  wire        hready;
	output reg  [31:0] hrdata;
	output reg         hreadyout;
	output reg         hresp;
	input  wire        suspend_req;
	input  wire        pin_direction_bit;
	input  wire        pin_out_value;
	input  wire        shared_port_pin_in;
	output reg         shared_port_pin_out;
	output reg         shared_port_pin_oe;
	output reg         pin_in_value;

	////////////////////////////////////////////////////////////////////////
	// control register

	reg        clk_out_enable_ff;
	reg        run_in_suspend_ff;
	reg  [7:0] divide_value_ff;
	reg        wr_pend_ff;
	reg        wr_half_ff;
	reg        rd_pend_ff;
	reg        nxt_wr_pend;
	reg        nxt_rd_pend;

	wire addr_phase = hsel & hready & (htrans == `ECP_HTRANS_NONSEQ);
	wire addr_hit   = (haddr[`ECP_AW-1:0] == `ECP_OFF_CTRL);
	// hprot[1] is the privileged marker; user writes complete but change nothing
	wire priv_write_access = hprot[`ECP_PRIV_BIT];
	wire size_ok = (hsize == `ECP_HSIZE_HALF) | (hsize == `ECP_HSIZE_WORD);

	always @* begin
		nxt_wr_pend = addr_phase & hwrite & addr_hit & priv_write_access & size_ok;
		nxt_rd_pend = addr_phase & ~hwrite & addr_hit;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_half_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			// halfword at offset 2 would target the upper, empty half
			wr_half_ff <= (hsize == `ECP_HSIZE_HALF) & haddr[`ECP_HALF_SEL_BIT];
			rd_pend_ff <= nxt_rd_pend;
		end
	end

	// writes accepted regardless of suspend
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_out_enable_ff <= 1'b0;
			run_in_suspend_ff <= 1'b0;
			divide_value_ff   <= `ECP_DIV_RST;
		end else if (wr_pend_ff && !wr_half_ff) begin
			// bits 14:9 have no storage
			clk_out_enable_ff <= hwdata[`ECP_EN_BIT];
			run_in_suspend_ff <= hwdata[`ECP_SUSP_BIT];
			divide_value_ff   <= hwdata[`ECP_DIV_MSB:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (nxt_rd_pend)
				hrdata <= {16'h0000, clk_out_enable_ff, 6'h00, run_in_suspend_ff,
					divide_value_ff};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// suspend and pin inputs

	wire susp_s;
	wire pin_s;

	ecp_sync u_sync_susp (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d_in    (suspend_req),
		.q_out   (susp_s)
	);

	ecp_sync u_sync_pin (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d_in    (shared_port_pin_in),
		.q_out   (pin_s)
	);

	////////////////////////////////////////////////////////////////////////
	// divider and pin mux

	wire run_div = clk_out_enable_ff & (~susp_s | run_in_suspend_ff);
	wire ext_clk_out;

	// hclk stopping freezes every flop, so state survives standby
	ecp_divider u_div (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.run        (run_div),
		.pend_div   (divide_value_ff),
		.clk_level  (ext_clk_out),
		.period_end ()
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shared_port_pin_out <= 1'b0;
			shared_port_pin_oe  <= 1'b0;
			pin_in_value        <= 1'b0;
		end else begin
			pin_in_value <= pin_s;
			if (clk_out_enable_ff) begin
				// stopped clock in suspend parks the pin low, still driven
				shared_port_pin_out <= ext_clk_out & run_div;
				shared_port_pin_oe  <= 1'b1;
			end else begin
				shared_port_pin_out <= pin_out_value;
				shared_port_pin_oe  <= pin_direction_bit;
			end
		end
	end
endmodule // ecp_top

// ===== sim/ecp_pin_model.sv
// far side of the shared pin
`timescale 1ns/1ps
module ecp_pin_model (
	input  wire logic oe,
	input  wire logic drv,
	input  wire logic ext_val,
	output logic      pin
);
	// once released the pin shows the outside driver, not the last level
	assign pin = oe ? drv : ext_val;
endmodule // ecp_pin_model

// ===== sim/ecp_top_sva.sv
// assertions on the prescaler's ports
`timescale 1ns/1ps
module ecp_top_chk (
	input wire        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
	input wire [31:0] haddr, hwdata, hrdata,
	input wire [1:0]  htrans,
	input wire [2:0]  hsize,
	input wire [3:0]  hprot,
	input wire        suspend_req, pin_direction_bit, pin_out_value, shared_port_pin_in,
	input wire        shared_port_pin_out, shared_port_pin_oe, pin_in_value
);
	logic wp_ff, rp_ff, en_ff, run_ff;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// shadow of the control bits, taken from privileged writes only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wp_ff, rp_ff, en_ff, run_ff} <= 4'h0;
		end else begin
			wp_ff <= hsel && hready && htrans == 2'h2 && hwrite && hprot[1]
				&& haddr[11:0] == 12'h000 && hsize inside {3'h1, 3'h2}
				&& !(hsize == 3'h1 && haddr[1]);
			rp_ff <= hsel && hready && htrans == 2'h2 && !hwrite;
			if (wp_ff) begin
				{en_ff, run_ff} <= {hwdata[15], hwdata[8]};
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	property p_resp; hresp == 1'b0; endproperty
	a_resp: assert property (p_resp) else $error("response not okay");
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("wait state seen");
	property p_rst; $rose(hresetn) |-> !shared_port_pin_oe && hrdata == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("pin driven out of reset");
	property p_rd_idle; !rp_ff |-> hrdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
	property p_drive; en_ff [*3] |-> shared_port_pin_oe; endproperty
	a_drive: assert property (p_drive) else $error("enabled pin not driven");
	property p_gio;
		(!en_ff && $stable(pin_direction_bit) && $stable(pin_out_value)) [*4] |->
			shared_port_pin_oe == pin_direction_bit
			&& (!pin_direction_bit || shared_port_pin_out == pin_out_value);
	endproperty
	a_gio: assert property (p_gio) else $error("pin not handed to port");
	property p_susp; (en_ff && !run_ff && suspend_req) [*6] |-> !shared_port_pin_out; endproperty
	a_susp: assert property (p_susp) else $error("clock runs in suspend");
	property p_pin_in; $stable(shared_port_pin_in) [*4] |-> pin_in_value == shared_port_pin_in;
	endproperty
	a_pin_in: assert property (p_pin_in) else $error("pin input not seen");
endmodule // ecp_top_chk
bind ecp_top ecp_top_chk ecp_top_chk_inst (.*);

// ===== sim/external_clock_prescaler_bench.sv
// bench for the prescaler: bus tasks, pin period measurement
`timescale 1ns/1ps
module external_clock_prescaler_bench;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, susp = 0, dir = 0, dout = 0;
	logic        clk_run = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [3:0]  hprot = 4'h3;
	logic        hready, hreadyout, hresp, pin_out, pin_oe, pin_in, pin_val;
	int          miscompares = 0, n_checks = 0, n;
	// clk_run low freezes the clock, as standby does
	always #5 hclk = clk_run ? ~hclk : hclk;
	assign hready = hreadyout;
	ecp_top ecp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.suspend_req(susp), .pin_direction_bit(dir), .pin_out_value(dout),
		.shared_port_pin_in(pin_in), .shared_port_pin_out(pin_out),
		.shared_port_pin_oe(pin_oe), .pin_in_value(pin_val));
	ecp_pin_model ecp_pin_model_inst (.oe(pin_oe), .drv(pin_out), .ext_val(1'b1), .pin(pin_in));
	////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_rdy;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			report_and_stop;
		end
	endtask
	task bus(input logic w, input logic [31:0] a, d, input logic [2:0] sz, input logic [3:0] p);
		{hsel, htrans, hwrite, haddr, hsize, hprot} <= {1'b1, 2'h2, w, a, sz, p};
		wait_rdy;
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		wait_rdy;
		r = hrdata;
	endtask
	// first rise syncs, the next period may still use the old divide
	task period(input logic [31:0] exp);
		int c;
		repeat (3) begin
			c = 0;
			while (pin_out !== 1'b0 && c < 600) begin
				@(posedge hclk);
				c++;
			end
			while (pin_out !== 1'b1 && c < 600) begin
				@(posedge hclk);
				c++;
			end
		end
		chk(c, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, 32'h0, 0, 3'h2, 4'h3);
		chk(r, 32'h7);
		// pin input passes two sync stages and one output stage
		repeat (3) @(posedge hclk);
		chk({pin_oe, pin_val}, 32'h1);
		bus(0, 32'h10, 0, 3'h2, 4'h3);
		chk(r, 32'h0);
		bus(1, 32'h0, 32'h8003, 3'h2, 4'h1);
		bus(0, 32'h0, 0, 3'h2, 4'h3);
		chk(r, 32'h7);
		bus(1, 32'h0, 32'hfe03, 3'h2, 4'h3);
		bus(0, 32'h0, 0, 3'h2, 4'h3);
		chk(r, 32'h8003);
		period(4);
		bus(1, 32'h0, 32'h80ff, 3'h1, 4'h3);
		period(256);
		susp <= 1'b1;
		bus(1, 32'h0, 32'h8101, 3'h2, 4'h3);
		period(2);
		clk_run <= 1'b0;
		#103 clk_run = 1'b1;
		@(posedge hclk);
		bus(0, 32'h0, 0, 3'h2, 4'h3);
		chk(r, 32'h8101);
		period(2);
		bus(1, 32'h0, 32'h8001, 3'h2, 4'h3);
		repeat (6) @(posedge hclk);
		repeat (8) begin
			@(posedge hclk);
			chk(pin_out, 0);
		end
		susp <= 1'b0;
		bus(1, 32'h0, 32'h0, 3'h2, 4'h3);
		{dir, dout} <= 2'b11;
		repeat (4) @(posedge hclk);
		chk({pin_oe, pin_out}, 32'h3);
		report_and_stop;
	end
endmodule // external_clock_prescaler_bench
